// >>> hdl/icp_pkg.sv
package icp_pkg;
	// ***************************************
	// Register offsets (byte addresses)
	// ***************************************
	localparam logic [7:0] OFF_SETPT = 8'h00;
	localparam logic [7:0] OFF_TMF = 8'h04;
	localparam logic [7:0] OFF_PULSE = 8'h08;
	localparam logic [7:0] OFF_SCI_ID = 8'h0C;
	localparam logic [7:0] OFF_ENG_ID = 8'h10;
	localparam logic [7:0] OFF_QLK = 8'h14;
	localparam logic [7:0] OFF_MODE = 8'h18;
	localparam logic [7:0] OFF_SAFE = 8'h1C;
	localparam logic [7:0] OFF_MASK3 = 8'h20;
	localparam logic [7:0] OFF_MASK2 = 8'h24;
	localparam logic [7:0] OFF_MASK1 = 8'h28;
	localparam logic [7:0] OFF_MASK1W = 8'h2C;
	localparam logic [7:0] OFF_LAMP = 8'h30;
	localparam logic [7:0] OFF_LEVEL = 8'h34;
	localparam logic [7:0] OFF_ARM = 8'h38;
	localparam logic [7:0] OFF_HTR = 8'h3C;
	localparam logic [7:0] OFF_FS_PWR = 8'h40;
	localparam logic [7:0] OFF_ECAL = 8'h44;
	localparam logic [7:0] OFF_PWR = 8'h48;
	localparam logic [7:0] OFF_STEP = 8'h4C;
	localparam logic [7:0] OFF_BURST = 8'h50;
	localparam logic [7:0] OFF_HALT = 8'h54;
	localparam logic [7:0] OFF_STATUS = 8'h58;
	localparam logic [7:0] OFF_COUNT = 8'h5C;
	localparam logic [7:0] OFF_DELAY0 = 8'h60;
	localparam logic [7:0] OFF_DELAY4 = 8'h70;
	// ***************************************
	// Ranges, encodings and reset values
	// ***************************************
	localparam logic [11:0] SETPT_MIN = 12'h062;
	localparam logic [11:0] SETPT_MAX = 12'hF44;
	localparam logic [11:0] SETPT_RST = 12'h093;
	localparam logic [6:0] PKT_ID_MIN = 7'h40;
	localparam logic [6:0] PKT_ID_RST = 7'h40;
	localparam logic [5:0] DELAY_MAX = 6'h32;
	localparam logic [2:0] MODE_SURVIVAL = 3'h1;
	localparam logic [2:0] MODE_STANDBY = 3'h3;
	localparam logic [2:0] MODE_SCIENCE = 3'h5;
	localparam logic [3:0] MASK3_RST = 4'hE;
	localparam logic [3:0] MASK2_RST = 4'h6;
	localparam logic [3:0] MASK1_RST = 4'h8;
	localparam logic [1:0] MASK1W_RST = 2'h2;
	localparam logic [2:0] LAMP_OFF = 3'h0;
	localparam logic [2:0] LAMP_30W = 3'h4;
	localparam logic [2:0] PWR_BOTH_LIMIT = 3'h3;
	localparam logic [1:0] HTR_FAILSAFE = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// ***************************************
	// Field positions
	// ***************************************
	localparam int PWR_IDX_LSB = 4;
	localparam int HTR_VAL_BIT = 4;
	localparam int STEP_DIR_BIT = 16;
	localparam int BURST_STEP_LSB = 10;
	localparam int BURST_DIR_BIT = 17;
	localparam int BURST_SCAN_LSB = 18;
	// ***************************************
	// Timing
	// ***************************************
	localparam longint CLK_HZ = 100_000_000;
	localparam longint ARM_S = 10;
	localparam longint HTR_DECIMIN = 116;
	localparam longint FS_WIN_MIN = 10;
	localparam longint LAMP_WAIT_S = 3;
	localparam longint ARM_CYC = ARM_S * CLK_HZ;
	localparam longint HTR_CYC = HTR_DECIMIN * 6 * CLK_HZ;
	localparam longint FS_CYC = FS_WIN_MIN * 60 * CLK_HZ;
	localparam longint LAMP_CYC = LAMP_WAIT_S * CLK_HZ;
	localparam int CNT_W = 40;
	// Calibrator lamp configuration
	typedef struct packed {
		logic shdn_dis;
		logic fb_rad;
		logic [2:0] power;
	} icp_lamp_cfg_s;
	localparam icp_lamp_cfg_s LAMP_RST = '{shdn_dis: 1'b1, fb_rad: 1'b1, power: 3'h0};
endpackage

// >>> hdl/icp_cmd_unit.sv
module icp_cmd_unit import icp_pkg::*; #(
	parameter longint ARM_CYCLES = ARM_CYC,
	parameter longint HTR_CYCLES = HTR_CYC,
	parameter longint FS_CYCLES = FS_CYC,
	parameter longint LAMP_CYCLES = LAMP_CYC
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_B,
	// AXI4-Lite slave
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic [2:0] S_AXI_AWPROT,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic [2:0] S_AXI_ARPROT,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Scan pulse pin
	input wire logic SCAN_TICK,
	// Subsystem power and pulses
	output logic [7:0] PWR_A_ON,
	output logic [7:0] PWR_B_ON,
	output logic [3:0] RESET_LINES,
	output logic FMT_IRQ,
	// Held parameters
	output logic [11:0] BB_SETPOINT,
	output logic TMF_BUS_B,
	output logic [6:0] SCI_PACKET_ID,
	output logic [6:0] ENG_PACKET_ID,
	output logic [1:0] QUICKLOOK,
	output logic [29:0] SECTOR_DELAY,
	output logic [2:0] OPER_MODE,
	output logic SAFE_ENABLE,
	output logic [3:0] ECAL_ENABLE,
	// Calibrator lamps
	output logic [3:0] THREE_LAMP_MASK,
	output logic [3:0] TWO_LAMP_MASK,
	output logic [3:0] ONE_LAMP_MASK,
	output logic [1:0] ONE_WATT_LAMP_MASK,
	output icp_lamp_cfg_s LAMP_CFG,
	output logic LAMP_LEVEL,
	// Heaters and motor
	output logic [3:0] HEATER_ON,
	output logic [31:0] GRATING_STEP_COUNT
);
	// ***************************************
	// Types and helpers
	// ***************************************
	typedef enum logic [1:0] {B_IDLE, B_STEP, B_PAUSE} icp_burst_e;
	typedef enum logic {L_IDLE, L_WAIT} icp_lamp_e;

	// Number of ones in a nibble
	function automatic logic [2:0] ones(input logic [31:0] v);
		ones = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
	endfunction

	// ***************************************
	// Bus slave state
	// ***************************************
	logic [7:0] awaddr_q; // Held write address
	logic [31:0] wdata_q; // Strobe-masked data
	logic aw_have_q, w_have_q;
	logic wr_fire, wr_ok, wr_map, wr_en;
	logic [31:0] rd_data;
	logic rd_map;
	// Block state
	logic arm_q, fs_pwr_q, fs_win_q;
	logic [CNT_W-1:0] arm_cnt_q, fs_cnt_q, lamp_cnt_q;
	logic [CNT_W-1:0] htr_cnt_q [4];
	icp_burst_e b_state_q;
	icp_lamp_e l_state_q;
	icp_lamp_cfg_s pend_q; // Setting held during lamp wait
	logic [9:0] bursts_q, scans_q, scans_left_q;
	logic [6:0] steps_q, steps_left_q;
	logic b_dir_q;
	logic [5:0] delay_q [5];
	logic s1_q, s2_q, s3_q, scan_lvl_q, scan_prev_q;
	logic scan_edge;
	logic [31:0] step_delta; // Signed delta of a relative step

	assign wr_fire = aw_have_q & w_have_q & ~S_AXI_BVALID;
	assign wr_en = wr_fire & wr_ok;
	assign step_delta = wdata_q[STEP_DIR_BIT] ? -{16'h0000, wdata_q[15:0]}
		: {16'h0000, wdata_q[15:0]};

	// Accepted write to one offset
	function automatic logic wr_at(input logic [7:0] off);
		wr_at = wr_en && (awaddr_q == off);
	endfunction

	// Write channel capture and response
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				awaddr_q <= S_AXI_AWADDR;
				aw_have_q <= 1'b1;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				for (int i = 0; i < 4; i++) begin
					wdata_q[8*i +: 8] <= S_AXI_WSTRB[i] ? S_AXI_WDATA[8*i +: 8] : 8'h00;
				end
				w_have_q <= 1'b1;
				S_AXI_WREADY <= 1'b0;
			end
			// Both halves present: answer
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= !wr_map ? RESP_DECERR : (wr_ok ? RESP_OKAY : RESP_SLVERR);
			end
			// Response taken: reopen both channels
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
			end
		end
	end

	// Decode and range check of a write
	always_comb begin
		wr_map = 1'b1;
		wr_ok = 1'b0;
		case (awaddr_q)
			OFF_SETPT: wr_ok = wdata_q >= 32'(SETPT_MIN) && wdata_q <= 32'(SETPT_MAX);
			OFF_TMF, OFF_SAFE, OFF_LEVEL, OFF_FS_PWR: wr_ok = wdata_q <= 32'h0000_0001;
			OFF_PULSE: wr_ok = wdata_q <= 32'h0000_001F;
			OFF_SCI_ID, OFF_ENG_ID: wr_ok = wdata_q >= 32'(PKT_ID_MIN)
				&& wdata_q <= 32'h0000_007F;
			OFF_QLK: wr_ok = wdata_q <= 32'h0000_0003;
			OFF_MODE: wr_ok = wdata_q >= 32'(MODE_SURVIVAL) && wdata_q <= 32'(MODE_SCIENCE);
			OFF_MASK3: wr_ok = wdata_q <= 32'h0000_000F && ones(wdata_q) == 3'h3;
			OFF_MASK2: wr_ok = wdata_q <= 32'h0000_000F && ones(wdata_q) == 3'h2;
			OFF_MASK1: wr_ok = wdata_q <= 32'h0000_000F && ones(wdata_q) == 3'h1;
			OFF_MASK1W: wr_ok = wdata_q == 32'h0000_0001 || wdata_q == 32'h0000_0002;
			OFF_LAMP: wr_ok = l_state_q == L_IDLE && wdata_q[31:6] == '0
				&& wdata_q[3] == 1'b0 && wdata_q[2:0] <= LAMP_30W;
			OFF_ARM: wr_ok = wdata_q == 32'h0000_0001;
			// Door heaters need the arm, the failsafe one its window
			OFF_HTR: wr_ok = wdata_q[31:5] == '0 && wdata_q[3:2] == 2'b00
				&& (wdata_q[1:0] == HTR_FAILSAFE ? fs_win_q : arm_q);
			OFF_ECAL: wr_ok = wdata_q <= 32'h0000_000F;
			OFF_PWR: wr_ok = wdata_q[31:7] == '0 && wdata_q[3:2] == 2'b00
				&& (wdata_q[1:0] != 2'h3 || wdata_q[6:4] < PWR_BOTH_LIMIT);
			OFF_STEP: wr_ok = b_state_q == B_IDLE && wdata_q[31:17] == '0;
			OFF_BURST: wr_ok = wdata_q[31:28] == '0 && wdata_q[9:0] != '0
				&& wdata_q[16:10] != '0;
			OFF_HALT: wr_ok = 1'b1;
			OFF_STATUS, OFF_COUNT: wr_ok = 1'b0;
			default: begin
				wr_map = awaddr_q >= OFF_DELAY0 && awaddr_q <= OFF_DELAY4 && awaddr_q[1:0] == 2'b00;
				wr_ok = wr_map && wdata_q <= 32'(DELAY_MAX);
			end
		endcase
	end

	// Read data mux, straight from the request address
	always_comb begin
		rd_map = 1'b1;
		rd_data = 32'h0000_0000;
		case (S_AXI_ARADDR)
			OFF_SETPT: rd_data = 32'(BB_SETPOINT);
			OFF_TMF: rd_data = 32'(TMF_BUS_B);
			OFF_PULSE, OFF_ARM, OFF_HALT: rd_data = 32'h0000_0000;
			OFF_SCI_ID: rd_data = 32'(SCI_PACKET_ID);
			OFF_ENG_ID: rd_data = 32'(ENG_PACKET_ID);
			OFF_QLK: rd_data = 32'(QUICKLOOK);
			OFF_MODE: rd_data = 32'(OPER_MODE);
			OFF_SAFE: rd_data = 32'(SAFE_ENABLE);
			OFF_MASK3: rd_data = 32'(THREE_LAMP_MASK);
			OFF_MASK2: rd_data = 32'(TWO_LAMP_MASK);
			OFF_MASK1: rd_data = 32'(ONE_LAMP_MASK);
			OFF_MASK1W: rd_data = 32'(ONE_WATT_LAMP_MASK);
			OFF_LAMP: rd_data = {26'h0, LAMP_CFG.shdn_dis, LAMP_CFG.fb_rad, 1'b0, LAMP_CFG.power};
			OFF_LEVEL: rd_data = 32'(LAMP_LEVEL);
			OFF_HTR: rd_data = 32'(HEATER_ON);
			OFF_FS_PWR: rd_data = 32'(fs_pwr_q);
			OFF_ECAL: rd_data = 32'(ECAL_ENABLE);
			OFF_PWR: rd_data = {16'h0000, PWR_B_ON, PWR_A_ON};
			OFF_STATUS: rd_data = {26'h0, b_state_q != B_IDLE, l_state_q == L_WAIT,
				fs_win_q, arm_q, 2'b00};
			OFF_COUNT: rd_data = GRATING_STEP_COUNT;
			default: begin
				rd_map = S_AXI_ARADDR >= OFF_DELAY0 && S_AXI_ARADDR <= OFF_DELAY4
					&& S_AXI_ARADDR[1:0] == 2'b00;
				rd_data = rd_map ? 32'(delay_q[S_AXI_ARADDR[4:2]]) : 32'h0000_0000;
			end
		endcase
	end

	// Read channel
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_data;
			S_AXI_RRESP <= rd_map ? RESP_OKAY : RESP_DECERR;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end

	// ***************************************
	// Held parameters
	// ***************************************
	// Plain settings, kept when a write is refused
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			BB_SETPOINT <= SETPT_RST;
			TMF_BUS_B <= 1'b0;
			SCI_PACKET_ID <= PKT_ID_RST;
			ENG_PACKET_ID <= PKT_ID_RST;
			QUICKLOOK <= 2'b00;
			OPER_MODE <= MODE_STANDBY;
			SAFE_ENABLE <= 1'b0;
			ECAL_ENABLE <= 4'h0;
			THREE_LAMP_MASK <= MASK3_RST;
			TWO_LAMP_MASK <= MASK2_RST;
			ONE_LAMP_MASK <= MASK1_RST;
			ONE_WATT_LAMP_MASK <= MASK1W_RST;
			LAMP_LEVEL <= 1'b1;
		end else begin
			if (wr_at(OFF_SETPT)) BB_SETPOINT <= wdata_q[11:0];
			if (wr_at(OFF_TMF)) TMF_BUS_B <= wdata_q[0];
			if (wr_at(OFF_SCI_ID)) SCI_PACKET_ID <= wdata_q[6:0];
			if (wr_at(OFF_ENG_ID)) ENG_PACKET_ID <= wdata_q[6:0];
			if (wr_at(OFF_QLK)) QUICKLOOK <= wdata_q[1:0];
			if (wr_at(OFF_MODE)) OPER_MODE <= wdata_q[2:0];
			if (wr_at(OFF_SAFE)) SAFE_ENABLE <= wdata_q[0];
			if (wr_at(OFF_ECAL)) ECAL_ENABLE <= wdata_q[3:0];
			if (wr_at(OFF_MASK3)) THREE_LAMP_MASK <= wdata_q[3:0];
			if (wr_at(OFF_MASK2)) TWO_LAMP_MASK <= wdata_q[3:0];
			if (wr_at(OFF_MASK1)) ONE_LAMP_MASK <= wdata_q[3:0];
			if (wr_at(OFF_MASK1W)) ONE_WATT_LAMP_MASK <= wdata_q[1:0];
			if (wr_at(OFF_LEVEL)) LAMP_LEVEL <= wdata_q[0];
		end
	end

	// Five sector delays, flattened onto the output
	always_ff @(posedge REF_CLK) begin
		for (int i = 0; i < 5; i++) begin
			if (!RST_B) begin
				delay_q[i] <= 6'h00;
				SECTOR_DELAY[6*i +: 6] <= 6'h00;
			end else if (wr_en && awaddr_q == OFF_DELAY0 + 8'(4 * i)) begin
				delay_q[i] <= wdata_q[5:0];
				SECTOR_DELAY[6*i +: 6] <= wdata_q[5:0];
			end
		end
	end

	// Redundant side power: each write sets both sides; both on allowed only at index 0 to 2
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			PWR_A_ON <= 8'h00;
			PWR_B_ON <= 8'h00;
		end else if (wr_at(OFF_PWR)) begin
			PWR_A_ON[wdata_q[6:4]] <= wdata_q[0];
			PWR_B_ON[wdata_q[6:4]] <= wdata_q[1];
		end
	end

	// Single-cycle reset and interrupt test pulses, idle low
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			RESET_LINES <= 4'h0;
			FMT_IRQ <= 1'b0;
		end else begin
			RESET_LINES <= wr_at(OFF_PULSE) ? wdata_q[3:0] : 4'h0;
			FMT_IRQ <= wr_at(OFF_PULSE) & wdata_q[4];
		end
	end

	// ***************************************
	// Paraffin heaters
	// ***************************************
	// Arm window counts down from receipt
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			arm_q <= 1'b0;
			arm_cnt_q <= '0;
		end else if (wr_at(OFF_ARM)) begin
			arm_q <= 1'b1;
			arm_cnt_q <= CNT_W'(ARM_CYCLES - 1);
		end else if (arm_q) begin
			if (arm_cnt_q == '0) arm_q <= 1'b0;
			arm_cnt_q <= arm_cnt_q - 1'b1;
		end
	end

	// Failsafe circuit power opens the command window
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			fs_pwr_q <= 1'b0;
			fs_win_q <= 1'b0;
			fs_cnt_q <= '0;
		end else if (wr_at(OFF_FS_PWR)) begin
			fs_pwr_q <= wdata_q[0];
			if (wdata_q[0] && !fs_pwr_q) begin
				fs_win_q <= 1'b1;
				fs_cnt_q <= CNT_W'(FS_CYCLES - 1);
			end else if (!wdata_q[0]) begin
				fs_win_q <= 1'b0;
			end
		end else if (fs_win_q) begin
			if (fs_cnt_q == '0) fs_win_q <= 1'b0;
			fs_cnt_q <= fs_cnt_q - 1'b1;
		end
	end

	// Value 0 turns on, 1 turns off; timer forces off
	always_ff @(posedge REF_CLK) begin
		for (int i = 0; i < 4; i++) begin
			if (!RST_B) begin
				HEATER_ON[i] <= 1'b0;
				htr_cnt_q[i] <= '0;
			end else if (wr_at(OFF_HTR) && wdata_q[1:0] == 2'(i)) begin
				HEATER_ON[i] <= ~wdata_q[HTR_VAL_BIT];
				htr_cnt_q[i] <= CNT_W'(HTR_CYCLES - 1);
			end else if (HEATER_ON[i]) begin
				if (htr_cnt_q[i] == '0) HEATER_ON[i] <= 1'b0;
				htr_cnt_q[i] <= htr_cnt_q[i] - 1'b1;
			end
		end
	end

	// ***************************************
	// Calibrator lamp change sequence
	// ***************************************
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			l_state_q <= L_IDLE;
			LAMP_CFG <= LAMP_RST;
			pend_q <= LAMP_RST;
			lamp_cnt_q <= '0;
		end else begin
			case (l_state_q)
				// Lamps off first, then wait
				L_IDLE: if (wr_at(OFF_LAMP)) begin
					pend_q <= '{shdn_dis: wdata_q[5], fb_rad: wdata_q[4], power: wdata_q[2:0]};
					LAMP_CFG.power <= LAMP_OFF;
					lamp_cnt_q <= CNT_W'(LAMP_CYCLES - 1);
					l_state_q <= L_WAIT;
				end
				// Apply; stay dark if shutdown was just disabled
				L_WAIT: if (lamp_cnt_q == '0) begin
					LAMP_CFG.shdn_dis <= pend_q.shdn_dis;
					LAMP_CFG.fb_rad <= pend_q.fb_rad;
					LAMP_CFG.power <= (pend_q.shdn_dis && !LAMP_CFG.shdn_dis)
						? LAMP_OFF : pend_q.power;
					l_state_q <= L_IDLE;
				end else begin
					lamp_cnt_q <= lamp_cnt_q - 1'b1;
				end
				default: l_state_q <= L_IDLE;
			endcase
		end
	end

	// ***************************************
	// Grating motor
	// ***************************************
	// Scan pin: three flops, change taken when 2nd and 3rd agree
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			{s1_q, s2_q, s3_q, scan_lvl_q, scan_prev_q} <= 5'h00;
		end else begin
			s1_q <= SCAN_TICK;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) scan_lvl_q <= s3_q;
			scan_prev_q <= scan_lvl_q;
		end
	end
	assign scan_edge = scan_lvl_q & ~scan_prev_q;

	// Burst sequencer: one step a cycle, pause in scans
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			b_state_q <= B_IDLE;
			{bursts_q, scans_q, scans_left_q} <= '0;
			{steps_q, steps_left_q} <= '0;
			b_dir_q <= 1'b0;
		end else if (wr_at(OFF_HALT)) begin
			b_state_q <= B_IDLE;
		end else if (wr_at(OFF_BURST)) begin
			bursts_q <= wdata_q[9:0];
			steps_q <= wdata_q[16:10];
			steps_left_q <= wdata_q[16:10];
			b_dir_q <= wdata_q[BURST_DIR_BIT];
			scans_q <= wdata_q[27:18];
			b_state_q <= B_STEP;
		end else begin
			case (b_state_q)
				B_IDLE: b_state_q <= B_IDLE;
				B_STEP: begin
					steps_left_q <= steps_left_q - 1'b1;
					if (steps_left_q == 7'h01) begin
						bursts_q <= bursts_q - 1'b1;
						scans_left_q <= scans_q;
						b_state_q <= (bursts_q == 10'h001) ? B_IDLE : B_PAUSE;
					end
				end
				B_PAUSE: begin
					if (scans_left_q == 10'h000) begin
						steps_left_q <= steps_q;
						b_state_q <= B_STEP;
					end else if (scan_edge) begin
						scans_left_q <= scans_left_q - 1'b1;
					end
				end
				default: b_state_q <= B_IDLE;
			endcase
		end
	end

	// Absolute step count
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			GRATING_STEP_COUNT <= 32'h0000_0000;
		end else if (wr_at(OFF_STEP)) begin
			GRATING_STEP_COUNT <= GRATING_STEP_COUNT + step_delta;
		end else if (b_state_q == B_STEP && !wr_at(OFF_HALT)) begin
			GRATING_STEP_COUNT <= b_dir_q ? GRATING_STEP_COUNT - 32'h0000_0001
				: GRATING_STEP_COUNT + 32'h0000_0001;
		end
	end

	// ***************************************
	// Assertions
	// ***************************************
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);

	sequence s_lamp_cmd;
		wr_at(OFF_LAMP);
	endsequence
	sequence s_lamp_dark;
		LAMP_CFG.power == LAMP_OFF && l_state_q == L_WAIT;
	endsequence
	sequence s_halt;
		wr_at(OFF_HALT);
	endsequence

	property p_ab_excl;
		((PWR_A_ON & PWR_B_ON) & 8'hF8) == 8'h00;
	endproperty
	a_ab_excl: assert property (p_ab_excl) else $error("both sides on");
	property p_reset_pulse;
		RESET_LINES != 4'h0 |=> RESET_LINES == 4'h0;
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse long");
	property p_irq_pulse;
		wr_at(OFF_PULSE) && wdata_q[4] |=> FMT_IRQ ##1 !FMT_IRQ;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse wrong");
	property p_setpt;
		BB_SETPOINT >= SETPT_MIN && BB_SETPOINT <= SETPT_MAX;
	endproperty
	a_setpt: assert property (p_setpt) else $error("setpoint out of range");
	property p_reject;
		wr_fire && !wr_ok |=> $stable(BB_SETPOINT) && $stable(OPER_MODE) && $stable(THREE_LAMP_MASK);
	endproperty
	a_reject: assert property (p_reject) else $error("refused write stored");
	property p_arm_expire;
		arm_q && arm_cnt_q == '0 && !wr_at(OFF_ARM) |=> !arm_q;
	endproperty
	a_arm_expire: assert property (p_arm_expire) else $error("arm not cancelled");
	property p_htr_arm;
		$rose(HEATER_ON[0]) |-> $past(arm_q);
	endproperty
	a_htr_arm: assert property (p_htr_arm) else $error("heater on unarmed");
	property p_lamp_dark;
		s_lamp_cmd |=> s_lamp_dark;
	endproperty
	a_lamp_dark: assert property (p_lamp_dark) else $error("lamps not off");
	property p_halt;
		s_halt |=> b_state_q == B_IDLE ##1 $stable(GRATING_STEP_COUNT);
	endproperty
	a_halt: assert property (p_halt) else $error("count moved after halt");
	property p_step;
		wr_at(OFF_STEP) |=> GRATING_STEP_COUNT == $past(GRATING_STEP_COUNT) + $past(step_delta);
	endproperty
	a_step: assert property (p_step) else $error("step delta wrong");
endmodule

// >>> verification/icp_bus_ctl.sv
module icp_bus_ctl (
	// Clock
	input wire logic clk,
	// Write channels
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read channels
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic tmo; // Wait ran out
	// ****************
	// Bus cycles
	// ****************
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready, tmo} = '0;
	end
	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 500);
		r = bresp;
		tmo = (n >= 500);
		bready <= 1'b0;
		@(posedge clk);
	endtask
	// Read: hold request until taken, answer taken at its own edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 500);
		d = rdata;
		r = rresp;
		tmo = (n >= 500);
		rready <= 1'b0;
		@(posedge clk);
	endtask
endmodule

// >>> verification/instrument_command_parameter_unit_tb.sv
module instrument_command_parameter_unit_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import icp_pkg::*;
	logic clk = 1'b0, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr, pa, pb;
	logic [31:0] wdata, rdata, x = 32'h0000_3B23, d, e, cnt;
	logic [1:0] bresp, rresp, r;
	logic [11:0] setp;
	logic [6:0] v, sid;
	logic [2:0] mode;
	int n_errors = 0, total_checks = 0;
	logic [3:0] strb = 4'hF, tick = 4'h0, htr, m2, rl; // Strobe, scan divider, watched outputs
	logic [4:0] seen = 5'h00, lamp; // Pulses seen so far, lamp setting
	logic [29:0] dly;
	logic irq;
	// ****************
	// Design and bus partner
	// ****************
	always #5 clk = ~clk;
	icp_cmd_unit #(.ARM_CYCLES(50), .HTR_CYCLES(200), .FS_CYCLES(100), .LAMP_CYCLES(20)) u_dut (
		.REF_CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(strb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SCAN_TICK(tick[3]), .PWR_A_ON(pa),
		.PWR_B_ON(pb), .RESET_LINES(rl), .FMT_IRQ(irq), .BB_SETPOINT(setp), .TMF_BUS_B(),
		.SCI_PACKET_ID(sid), .ENG_PACKET_ID(), .QUICKLOOK(), .SECTOR_DELAY(dly),
		.OPER_MODE(mode), .SAFE_ENABLE(), .ECAL_ENABLE(), .THREE_LAMP_MASK(),
		.TWO_LAMP_MASK(m2), .ONE_LAMP_MASK(), .ONE_WATT_LAMP_MASK(), .LAMP_CFG(lamp),
		.LAMP_LEVEL(), .HEATER_ON(htr), .GRATING_STEP_COUNT(cnt));
	// Scan pulse every 16 cycles
	always @(posedge clk) tick <= tick + 4'h1;
	// Remember every one-cycle pulse once out of reset
	always @(posedge clk) if (rst_b) seen <= seen | {irq, rl};
	icp_bus_ctl u_bus (.clk(clk), .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	// ****************
	// Helpers
	// ****************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] x_e);
		total_checks++;
		if (g !== x_e) begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, g, x_e);
		end
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Cut a hung bus wait short
	always @(posedge clk) if (u_bus.tmo === 1'b1) begin
		n_errors++;
		conclude();
	end
	// ****************
	// Scenarios
	// ****************
	initial begin
		rst_b = 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk(setp, SETPT_RST);
		chk(mode, MODE_STANDBY);
		u_bus.wr(OFF_SETPT, SETPT_MAX + 1, r);
		chk(r, RESP_SLVERR);
		chk(setp, SETPT_RST);
		u_bus.wr(OFF_SETPT, SETPT_MIN, r);
		u_bus.rd(OFF_SETPT, d, r);
		chk(d, SETPT_MIN);
		// Upper lane masked off leaves 044, below range
		strb <= 4'h1;
		u_bus.wr(OFF_SETPT, 32'h0000_0F44, r);
		chk(r, RESP_SLVERR);
		chk(setp, SETPT_MIN);
		strb <= 4'hF;
		e = PKT_ID_RST;
		chk(sid, e);
		for (int i = 0; i < 8; i++) begin
			x = lfsr(x);
			v = x[6:0];
			u_bus.wr(OFF_SCI_ID, v, r);
			if (v >= PKT_ID_MIN) e = v;
			chk(r, (v >= PKT_ID_MIN) ? RESP_OKAY : RESP_SLVERR);
			chk(sid, e);
		end
		for (int m = 1; m < 7; m++) begin
			u_bus.wr(OFF_MODE, m, r);
			chk(mode, (m < 6) ? m : 5);
		end
		u_bus.wr(OFF_PWR, 32'h0000_0033, r);
		chk(r, RESP_SLVERR);
		u_bus.wr(OFF_PWR, 32'h0000_0031, r);
		chk({pb, pa}, 16'h0008);
		u_bus.wr(OFF_PWR, 32'h0000_0032, r);
		chk({pb, pa}, 16'h0800);
		u_bus.wr(OFF_PWR, 32'h0000_0003, r);
		chk({pb, pa}, 16'h0901);
		u_bus.wr(OFF_STEP, 32'h0001_0005, r);
		chk(cnt, 32'hFFFF_FFFB);
		// Two bursts of three forward steps, one scan apart
		u_bus.wr(OFF_BURST, 32'h0004_0C02, r);
		repeat (60) @(posedge clk);
		chk(cnt, 32'h0000_0001);
		u_bus.wr(OFF_BURST, 32'h0000_07FF, r);
		u_bus.wr(OFF_HALT, 32'h0000_0000, r);
		d = cnt;
		repeat (9) @(posedge clk);
		chk(cnt, d);
		// Heater refused unarmed, then on, timed off, arm lapses
		u_bus.wr(OFF_HTR, 32'h0000_0000, r);
		chk(r, RESP_SLVERR);
		u_bus.wr(OFF_ARM, 32'h0000_0001, r);
		u_bus.wr(OFF_HTR, 32'h0000_0000, r);
		chk(htr, 4'h1);
		repeat (200) @(posedge clk);
		chk(htr, 4'h0);
		u_bus.wr(OFF_HTR, 32'h0000_0010, r);
		chk(r, RESP_SLVERR);
		// Lamps dark during the wait, then new setting
		u_bus.wr(OFF_LAMP, 32'h0000_0014, r);
		chk(lamp, 5'h18);
		repeat (25) @(posedge clk);
		chk(lamp, 5'h0C);
		u_bus.wr(OFF_LAMP, 32'h0000_0034, r);
		repeat (25) @(posedge clk);
		chk(lamp, 5'h18);
		// Every nibble against the two-lamp mask
		e = MASK2_RST;
		chk(m2, e);
		for (int i = 0; i < 16; i++) begin
			u_bus.wr(OFF_MASK2, i, r);
			if ($countones(i) == 2) e = i;
			chk(m2, e);
		end
		u_bus.wr(OFF_DELAY0 + 8'h08, 32'h0000_0032, r);
		u_bus.wr(OFF_DELAY0 + 8'h08, 32'h0000_0033, r);
		chk(dly, 32'h0003_2000);
		chk(seen, 5'h00);
		u_bus.wr(OFF_PULSE, 32'h0000_001F, r);
		chk(seen, 5'h1F);
		chk({irq, rl}, 5'h00);
		u_bus.rd(8'h7C, d, r);
		chk(r, RESP_DECERR);
		conclude();
	end
endmodule
